/* File: fgss_consts.svh */
// Constants for the flow guard and shadow stack block.
// Assumes inclusion by the design module only.
`ifndef FGSS_CONSTS_SVH
`define FGSS_CONSTS_SVH
`define FGSS_USER_CTRL_ADDR 12'h6a0
`define FGSS_SUPV_CTRL_ADDR 12'h6a2
`define FGSS_SHSTK_EN_BIT 0
`define FGSS_CTRL_RESET 64'h0000000000000000
`define FGSS_SSP_RESET 64'h0000000000000000
`define FGSS_USER_LEVEL 2'h3
`define FGSS_CP_VECTOR 8'h15
`define FGSS_WORD_BYTES 64'h0000000000000004
`define FGSS_DWORD_BYTES 64'h0000000000000008
`endif

/* File: fgss_pkg.sv */
// Types shared by the flow guard and shadow stack block.
// Assumes the constants header sits in the same folder.
package fgss_pkg;
  typedef enum logic [2:0] {
    FGSS_OP_NONE,
    FGSS_OP_PUSH_WORD,
    FGSS_OP_PUSH_DWORD,
    FGSS_OP_POP_WORD,
    FGSS_OP_POP_DWORD,
    FGSS_OP_CMPXCHG,
    FGSS_OP_CALL,
    FGSS_OP_RET
  } fgss_op_t;

  // One retiring instruction as seen by the guard.
  typedef struct packed {
    logic valid;
    logic indirect_branch;
    logic landing_marker;
    logic ordinary_store;
    fgss_op_t op;
    logic [63:0] operand;
    logic [63:0] expected;
    logic [63:0] ssp_load;
    logic ssp_load_en;
  } fgss_instr_t;

  // One shadow stack memory request.
  typedef struct packed {
    logic valid;
    logic write;
    logic shadow_tag;
    logic lock;
    logic unlock;
    logic [3:0] bytes;
    logic [63:0] addr;
    logic [63:0] wdata;
  } fgss_mreq_t;

  // Memory answer.
  typedef struct packed {
    logic valid;
    logic fault;
    logic shadow_page;
    logic [63:0] rdata;
  } fgss_mrsp_t;
endpackage

/* File: fgss_guard.sv */
// Flow guard: landing-marker tracker plus shadow stack unit.
// Assumes one instruction presented per busy-free cycle and a memory that answers later.
`timescale 1ns/1ps
`include "fgss_consts.svh"

module fgss_guard (
  input wire logic clk, // Core clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire fgss_pkg::fgss_instr_t instr, // Retiring instruction.
  input wire logic [1:0] current_privilege_level, // Current level.
  input wire logic master_guard_enable, // Master guard enable.
  input wire logic protected_mode_enable, // Protected mode enable.
  input wire logic virtual8086_flag, // Virtual-8086 flag.
  input wire logic long_mode, // High in 64-bit mode.
  input wire logic ctrl_wr, // Control register write strobe.
  input wire logic [11:0] ctrl_addr, // Control register address.
  input wire logic [63:0] ctrl_wdata, // Control register write data.
  input wire fgss_pkg::fgss_mrsp_t mrsp, // Memory answer.
  output fgss_pkg::fgss_mreq_t mreq, // Memory request.
  output logic [63:0] ctrl_rdata, // Control register read data.
  output logic [63:0] result, // Popped or exchanged value.
  output logic result_valid, // Result pulse.
  output logic busy, // Unit busy, hold instruction.
  output logic shadow_enabled_query, // Enabled at current level.
  output logic control_protection_fault, // Fault pulse.
  output logic [7:0] fault_vector, // Vector for the fault.
  output logic page_fault, // Non-shadow page or access fault pulse.
  output logic store_blocked, // Ordinary store refused.
  output logic [63:0] ssp // Shadow stack pointer view.
);
  import fgss_pkg::*;

  typedef enum logic {FGSS_IDLE, FGSS_AWAIT} fgss_trk_t;
  typedef enum logic [2:0] {FGSS_S_IDLE, FGSS_S_WAIT, FGSS_S_LOCK, FGSS_S_UNLOCK}
    fgss_st_t;

  //////////////////////////////////////////////////////////////////////////////
  // Enable decode, used for the live query and when ops start.
  function automatic logic fgss_enabled(input logic [1:0] lvl, input logic [63:0] u,
                                        input logic [63:0] s, input logic m,
                                        input logic p, input logic v);
    logic bit_sel;
    bit_sel = (lvl == `FGSS_USER_LEVEL) ? u[`FGSS_SHSTK_EN_BIT]
                                        : s[`FGSS_SHSTK_EN_BIT];
    return m && p && !v && bit_sel;
  endfunction

  // Narrows to 32 bits outside 64-bit mode.
  function automatic logic [63:0] fgss_width(input logic lm, input logic [63:0] x);
    return lm ? x : {32'h00000000, x[31:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State.
  fgss_trk_t trk_q, trk_d;
  fgss_st_t st_q, st_d;
  fgss_op_t op_q, op_d;
  logic [63:0] user_q, user_d, supv_q, supv_d;
  logic [63:0] ssp_q, ssp_d, addr_q, addr_d, new_q, new_d, exp_q, exp_d;
  logic [63:0] old_q, old_d, crd_q, crd_d;
  fgss_mreq_t mreq_q, mreq_d;
  logic [63:0] rdata_q, rdata_d;
  logic rv_q, rv_d, cp_q, cp_d, pf_q, pf_d, sb_q, sb_d, en_q, en_d;
  logic lm_q, lm_d;
  logic busy_q, busy_d;

  logic en_now;
  logic [63:0] step;

  assign en_now = fgss_enabled(current_privilege_level, user_q, supv_q,
                               master_guard_enable, protected_mode_enable, virtual8086_flag);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for tracker, control registers and stack unit.
  always_comb begin
    trk_d = trk_q;
    st_d = st_q;
    op_d = op_q;
    user_d = user_q;
    supv_d = supv_q;
    ssp_d = ssp_q;
    addr_d = addr_q;
    new_d = new_q;
    exp_d = exp_q;
    old_d = old_q;
    lm_d = lm_q;
    rdata_d = rdata_q;
    mreq_d = mreq_q;
    rv_d = 1'b0;
    cp_d = 1'b0;
    pf_d = 1'b0;
    sb_d = 1'b0;
    en_d = en_now;
    step = lm_q ? `FGSS_DWORD_BYTES : `FGSS_WORD_BYTES;
    if (ctrl_wr && ctrl_addr == `FGSS_USER_CTRL_ADDR) begin
      user_d = ctrl_wdata;
    end
    if (ctrl_wr && ctrl_addr == `FGSS_SUPV_CTRL_ADDR) begin
      supv_d = ctrl_wdata;
    end
    // Tracker: the marker itself changes nothing else in the unit.
    if (instr.valid && !busy) begin
      case (trk_q)
        FGSS_IDLE: begin
          if (instr.indirect_branch) begin
            trk_d = FGSS_AWAIT;
          end
        end
        FGSS_AWAIT: begin
          if (instr.landing_marker) begin
            trk_d = FGSS_IDLE;
          end else begin
            cp_d = 1'b1;
            trk_d = instr.indirect_branch ? FGSS_AWAIT : FGSS_IDLE;
          end
        end
        default: trk_d = FGSS_IDLE;
      endcase
      // Ordinary stores never reach the shadow stack.
      sb_d = instr.ordinary_store && en_now;
      if (instr.ssp_load_en) begin
        ssp_d = fgss_width(long_mode, instr.ssp_load);
      end
    end
    // Stack unit.
    case (st_q)
      FGSS_S_IDLE: begin
        mreq_d.valid = 1'b0;
        if (instr.valid && en_now && instr.op != FGSS_OP_NONE) begin
          op_d = instr.op;
          lm_d = long_mode;
          new_d = instr.operand;
          exp_d = instr.expected;
          mreq_d.shadow_tag = 1'b1;
          mreq_d.lock = 1'b0;
          mreq_d.unlock = 1'b0;
          mreq_d.valid = 1'b1;
          st_d = FGSS_S_WAIT;
          case (instr.op)
            FGSS_OP_PUSH_WORD, FGSS_OP_PUSH_DWORD, FGSS_OP_CALL: begin
              step = (instr.op == FGSS_OP_PUSH_WORD ||
                      (instr.op == FGSS_OP_CALL && !long_mode)) ? `FGSS_WORD_BYTES
                                                               : `FGSS_DWORD_BYTES;
              addr_d = fgss_width(long_mode, ssp_q - step);
              mreq_d.write = 1'b1;
              mreq_d.bytes = step[3:0];
              mreq_d.wdata = instr.operand;
            end
            FGSS_OP_POP_WORD, FGSS_OP_POP_DWORD, FGSS_OP_RET: begin
              step = (instr.op == FGSS_OP_POP_WORD ||
                      (instr.op == FGSS_OP_RET && !long_mode)) ? `FGSS_WORD_BYTES
                                                              : `FGSS_DWORD_BYTES;
              addr_d = ssp_q;
              mreq_d.write = 1'b0;
              mreq_d.bytes = step[3:0];
            end
            default: begin
              addr_d = instr.operand; // Exchange address comes in the operand.
              new_d = instr.ssp_load;
              mreq_d.write = 1'b0;
              mreq_d.lock = 1'b1;
              mreq_d.bytes = 4'h8;
              st_d = FGSS_S_LOCK;
            end
          endcase
          mreq_d.addr = (instr.op == FGSS_OP_PUSH_WORD || instr.op == FGSS_OP_PUSH_DWORD ||
                         instr.op == FGSS_OP_CALL) ? fgss_width(long_mode, ssp_q - step)
                        : (instr.op == FGSS_OP_CMPXCHG ? instr.operand : ssp_q);
        end
      end
      FGSS_S_WAIT: begin
        mreq_d.valid = 1'b0;
        if (mrsp.valid) begin
          st_d = FGSS_S_IDLE;
          if (mrsp.fault || !mrsp.shadow_page) begin
            pf_d = 1'b1;
          end else if (mreq_q.write) begin
            ssp_d = addr_q;
          end else begin
            ssp_d = fgss_width(lm_q, addr_q + {60'h0, mreq_q.bytes});
            rdata_d = mreq_q.bytes == 4'h4 ? {32'h00000000, mrsp.rdata[31:0]} : mrsp.rdata;
            rv_d = 1'b1;
            if (op_q == FGSS_OP_RET && rdata_d != new_q) begin
              cp_d = 1'b1;
            end
          end
        end
      end
      FGSS_S_LOCK: begin
        mreq_d.valid = 1'b0;
        if (mrsp.valid) begin
          if (mrsp.fault || !mrsp.shadow_page) begin
            pf_d = 1'b1;
            st_d = FGSS_S_IDLE;
          end else begin
            old_d = mrsp.rdata;
            mreq_d.valid = 1'b1;
            mreq_d.write = 1'b1;
            mreq_d.lock = 1'b0;
            mreq_d.unlock = 1'b1;
            mreq_d.wdata = (mrsp.rdata == exp_q) ? new_q : mrsp.rdata;
            st_d = FGSS_S_UNLOCK;
          end
        end
      end
      FGSS_S_UNLOCK: begin
        mreq_d.valid = 1'b0;
        if (mrsp.valid) begin
          pf_d = mrsp.fault || !mrsp.shadow_page;
          rdata_d = old_q;
          rv_d = 1'b1;
          mreq_d.unlock = 1'b0;
          st_d = FGSS_S_IDLE;
        end
      end
      default: st_d = FGSS_S_IDLE;
    endcase
    // Registered control read keeps every port a flop output, except the constant fault_vector.
    crd_d = (ctrl_addr == `FGSS_USER_CTRL_ADDR) ? user_q :
            (ctrl_addr == `FGSS_SUPV_CTRL_ADDR) ? supv_q : 64'h0;
    busy_d = (st_d != FGSS_S_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers; reset clears any pending marker demand.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trk_q <= FGSS_IDLE;
      st_q <= FGSS_S_IDLE;
      op_q <= FGSS_OP_NONE;
      user_q <= `FGSS_CTRL_RESET;
      supv_q <= `FGSS_CTRL_RESET;
      ssp_q <= `FGSS_SSP_RESET;
      addr_q <= 64'h0;
      new_q <= 64'h0;
      exp_q <= 64'h0;
      old_q <= 64'h0;
      crd_q <= 64'h0;
      busy_q <= 1'b0;
      lm_q <= 1'b0;
      rdata_q <= 64'h0;
      mreq_q <= '0;
      rv_q <= 1'b0;
      cp_q <= 1'b0;
      pf_q <= 1'b0;
      sb_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      trk_q <= trk_d;
      st_q <= st_d;
      op_q <= op_d;
      user_q <= user_d;
      supv_q <= supv_d;
      ssp_q <= ssp_d;
      addr_q <= addr_d;
      new_q <= new_d;
      exp_q <= exp_d;
      old_q <= old_d;
      crd_q <= crd_d;
      busy_q <= busy_d;
      lm_q <= lm_d;
      rdata_q <= rdata_d;
      mreq_q <= mreq_d;
      rv_q <= rv_d;
      cp_q <= cp_d;
      pf_q <= pf_d;
      sb_q <= sb_d;
      en_q <= en_d;
    end
  end

  // Busy has its own flop, loaded with the state that leaves idle.
  assign busy = busy_q;
  assign mreq = mreq_q;
  assign result = rdata_q;
  assign result_valid = rv_q;
  assign shadow_enabled_query = en_q;
  assign control_protection_fault = cp_q;
  assign fault_vector = `FGSS_CP_VECTOR;
  assign page_fault = pf_q;
  assign store_blocked = sb_q;
  assign ssp = ssp_q;
  // Control read data is registered, so it follows the address one cycle later.
  assign ctrl_rdata = crd_q;
endmodule

/* File: fgss_guard_props.sv */
// Concurrent checks on the flow guard ports.
// Assumes a bind onto fgss_guard from the bench top file.
`timescale 1ns/1ps
module fgss_guard_props (
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire fgss_pkg::fgss_instr_t instr, // Instruction.
  input wire logic master_guard_enable, // Master enable.
  input wire logic protected_mode_enable, // Mode enable.
  input wire logic virtual8086_flag, // V86 flag.
  input wire fgss_pkg::fgss_mrsp_t mrsp, // Memory answer.
  input wire fgss_pkg::fgss_mreq_t mreq, // Memory request.
  input wire logic busy, // Busy.
  input wire logic shadow_enabled_query, // Enabled view.
  input wire logic control_protection_fault, // Fault pulse.
  input wire logic [7:0] fault_vector, // Vector.
  input wire logic page_fault, // Page fault pulse.
  input wire logic store_blocked, // Store refused.
  input wire logic [63:0] ssp // Pointer.
);
  import fgss_pkg::*;
  logic aw_q;
  logic aw_d;
  logic lk_q;
  logic lk_d;
  logic take;
  ////////////////////////////////////////
  // Shadow of the tracker and of an open locked read, so faults can be predicted.
  assign take = instr.valid && !busy;
  always_comb begin
    aw_d = take ? instr.indirect_branch : aw_q;
    lk_d = (mreq.valid && mreq.lock) ? 1'b1 : (mrsp.valid ? 1'b0 : lk_q);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_q <= 1'b0;
      lk_q <= 1'b0;
    end else begin
      aw_q <= aw_d;
      lk_q <= lk_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_MARK_MISS: assert property (take && aw_q && !instr.landing_marker |=>
    control_protection_fault) else $error("missing marker not faulted");
  AST_MARK_NOP: assert property (take && instr.landing_marker && instr.op == FGSS_OP_NONE
    && !instr.ordinary_store |=> !control_protection_fault && !mreq.valid && !store_blocked)
    else $error("marker had an effect");
  AST_STORE: assert property (take && instr.ordinary_store && instr.op == FGSS_OP_NONE
    |=> store_blocked == shadow_enabled_query && !mreq.valid)
    else $error("ordinary store not refused");
  AST_TAG: assert property (mreq.valid |-> mreq.shadow_tag &&
    (mreq.bytes == 4'h4 || mreq.bytes == 4'h8)) else $error("bad request tag or size");
  AST_PUSH_ADDR: assert property (mreq.valid && mreq.write && !mreq.unlock |->
    mreq.addr == ssp - {60'h0, mreq.bytes}) else $error("push address wrong");
  AST_POP_ADDR: assert property (mreq.valid && !mreq.write && !mreq.lock |->
    mreq.addr == ssp) else $error("pop address wrong");
  AST_LOCK: assert property (mreq.valid && mreq.lock |-> !mreq.write &&
    mreq.bytes == 4'h8) else $error("locked read malformed");
  AST_UNLOCK: assert property (mrsp.valid && lk_q && !mrsp.fault && mrsp.shadow_page |=>
    mreq.valid && mreq.write && mreq.unlock) else $error("no unlocking store");
  AST_KEEP: assert property (mrsp.valid && (mrsp.fault || !mrsp.shadow_page) |=>
    page_fault && $stable(ssp)) else $error("faulting access moved pointer");
  AST_VEC: assert property (fault_vector == 8'h15) else $error("fault vector wrong");
  AST_DIS: assert property ($past(virtual8086_flag || !protected_mode_enable ||
    !master_guard_enable) |-> !shadow_enabled_query) else $error("enabled when off");
endmodule

/* File: fgss_mem.sv */
// Behavioural shadow stack memory facing the guard.
// Assumes one request in flight at a time.
`timescale 1ns/1ps
module fgss_mem (
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire fgss_pkg::fgss_mreq_t mreq, // Request.
  input wire logic slow, // Answer late.
  input wire logic bad_page, // Answer as a plain page.
  output fgss_pkg::fgss_mrsp_t mrsp // Answer.
);
  import fgss_pkg::*;
  logic [63:0] mem [logic [63:0]];
  fgss_mreq_t req_q;
  int wait_q;
  logic [63:0] rd;
  ////////////////////////////////////////
  // Answers after one or four cycles; idle data is inverted so stale values never match.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
      wait_q <= 0;
      mrsp <= '0;
    end else begin
      mrsp.valid <= 1'b0;
      mrsp.rdata <= ~mrsp.rdata;
      if (mreq.valid) begin
        req_q <= mreq;
        wait_q <= slow ? 4 : 1;
      end else if (wait_q == 1) begin
        wait_q <= 0;
        mrsp.valid <= 1'b1;
        mrsp.shadow_page <= !bad_page;
        rd = mem.exists(req_q.addr) ? mem[req_q.addr] : 64'h0;
        if (req_q.write && !bad_page) begin
          mem[req_q.addr] = req_q.bytes == 4'h4 ? {32'h0, req_q.wdata[31:0]} : req_q.wdata;
        end else if (!req_q.write) begin
          mrsp.rdata <= req_q.bytes == 4'h4 ? {32'h0, rd[31:0]} : rd;
        end
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

/* File: fgss_guard_bench.sv */
// Self-checking bench for the flow guard.
// Assumes the guard, its checker and the memory model are compiled first.
`timescale 1ns/1ps
module fgss_guard_bench;
  import fgss_pkg::*;
  logic clk, nrst, master_guard_enable, protected_mode_enable, virtual8086_flag, long_mode;
  logic ctrl_wr, result_valid, busy, shadow_enabled_query, control_protection_fault;
  logic page_fault, store_blocked, slow, bad, g_cpf, g_pf, g_sb;
  fgss_instr_t instr;
  fgss_mrsp_t mrsp;
  fgss_mreq_t mreq;
  logic [1:0] current_privilege_level;
  logic [11:0] ctrl_addr;
  logic [7:0] fault_vector;
  logic [63:0] ctrl_wdata, ctrl_rdata, result, ssp, res, d0, d1, nv, ra;
  logic [31:0] seed = 32'h191edf15;
  logic [31:0] r;
  int miscompares, total_checks, i;
  fgss_guard u_fgss_guard (.clk, .nrst, .instr, .current_privilege_level, .master_guard_enable,
    .protected_mode_enable, .virtual8086_flag, .long_mode, .ctrl_wr, .ctrl_addr, .ctrl_wdata,
    .mrsp, .mreq, .ctrl_rdata, .result, .result_valid, .busy, .shadow_enabled_query,
    .control_protection_fault, .fault_vector, .page_fault, .store_blocked, .ssp);
  fgss_mem u_fgss_mem (.clk, .nrst, .mreq, .slow, .bad_page(bad), .mrsp);
  ////////////////////////////////////////
  always #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic en_f(logic [1:0] c, logic m, logic p, logic v);
    return m && p && !v && (c == 2'h3);
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    ctrl_addr = a;
    ctrl_wdata = d;
    ctrl_wr = 1'b1;
    @(posedge clk);
    #1 ctrl_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Issue one instruction and gather pulses until the unit has been idle three cycles.
  task automatic op(input fgss_op_t o, input logic [63:0] a, input logic [63:0] e,
                    input logic [63:0] s);
    int n;
    int idle;
    instr.op = o;
    instr.operand = a;
    instr.expected = e;
    instr.ssp_load = s;
    instr.valid = 1'b1;
    @(posedge clk);
    #1 instr = '0;
    {g_cpf, g_pf, g_sb} = '0;
    idle = 0;
    for (n = 0; n < 40 && idle < 3; n++) begin
      g_cpf |= control_protection_fault;
      g_pf |= page_fault;
      g_sb |= store_blocked;
      if (result_valid) res = result;
      idle = busy ? 0 : idle + 1;
      @(posedge clk);
      #1;
    end
    if (idle < 3) begin
      miscompares++;
      stop_test();
    end
  endtask
  initial begin
    clk = 0;
    nrst = 0;
    instr = '0;
    {master_guard_enable, protected_mode_enable, virtual8086_flag, ctrl_wr, slow, bad} = '0;
    current_privilege_level = 2'h3;
    long_mode = 1;
    ctrl_addr = 12'h6a0;
    ctrl_wdata = '0;
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    chk(ctrl_rdata, 64'h0);
    chk(fault_vector, 64'h15);
    wr(12'h6a0, 64'h1);
    wr(12'h6a2, 64'h0);
    chk(ctrl_rdata, 64'h0);
    ctrl_addr = 12'h6a1;
    @(posedge clk);
    #1 chk(ctrl_rdata, 64'h0);
    ctrl_addr = 12'h6a0;
    @(posedge clk);
    #1 chk(ctrl_rdata, 64'h1);
    // Random level and mode mixes; only level 3 has its enable set.
    for (i = 0; i < 24; i++) begin
      r = rnd();
      {master_guard_enable, protected_mode_enable} = r[1:0] | {2{r[6]}};
      virtual8086_flag = r[2] & r[3];
      current_privilege_level = r[5:4];
      @(posedge clk);
      #1 chk(shadow_enabled_query, en_f(r[5:4], master_guard_enable,
        protected_mode_enable, virtual8086_flag));
    end
    {master_guard_enable, protected_mode_enable, virtual8086_flag} = 3'b110;
    current_privilege_level = 2'h3;
    instr.ssp_load_en = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 64'h1000);
    chk(ssp, 64'h1000);
    d0 = {rnd(), rnd()};
    d1 = {rnd(), rnd()};
    op(FGSS_OP_PUSH_DWORD, d0, 0, 0);
    chk(ssp, 64'hff8);
    op(FGSS_OP_PUSH_WORD, d1, 0, 0);
    chk(ssp, 64'hff4);
    chk(u_fgss_mem.mem[64'hff4], {32'h0, d1[31:0]});
    op(FGSS_OP_POP_WORD, 0, 0, 0);
    chk(res[31:0], d1[31:0]);
    chk(ssp, 64'hff8);
    // Equal then unequal exchange on the same slot, the second answered slowly.
    for (i = 0; i < 2; i++) begin
      slow = i[0];
      nv = {rnd(), rnd()};
      d1 = u_fgss_mem.mem[64'hff8];
      op(FGSS_OP_CMPXCHG, 64'hff8, i ? ~d1 : d1, nv);
      chk(res, d1);
      chk(u_fgss_mem.mem[64'hff8], i ? d1 : nv);
    end
    op(FGSS_OP_POP_DWORD, 0, 0, 0);
    chk(res, d1);
    chk(ssp, 64'h1000);
    ra = {32'h0, rnd()};
    long_mode = 0;
    op(FGSS_OP_CALL, ra, 0, 0);
    chk(ssp, 64'hffc);
    op(FGSS_OP_RET, ra, 0, 0);
    chk({g_cpf, ssp}, {1'b0, 64'h1000});
    long_mode = 1;
    op(FGSS_OP_CALL, ra, 0, 0);
    chk(ssp, 64'hff8);
    op(FGSS_OP_RET, ra ^ 64'h1, 0, 0);
    chk(g_cpf, 1);
    instr.ssp_load_en = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 64'h1000);
    bad = 1;
    op(FGSS_OP_PUSH_DWORD, d0, 0, 0);
    chk({g_pf, ssp}, {1'b1, 64'h1000});
    bad = 0;
    wr(12'h6a0, 64'h0);
    op(FGSS_OP_PUSH_DWORD, d0, 0, 0);
    chk(ssp, 64'h1000);
    instr.indirect_branch = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    instr.landing_marker = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    chk(g_cpf, 0);
    instr.indirect_branch = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    op(FGSS_OP_NONE, 0, 0, 0);
    chk(g_cpf, 1);
    instr.ordinary_store = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    chk(g_sb, 0);
    wr(12'h6a0, 64'h1);
    instr.ordinary_store = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    chk(g_sb, 1);
    // A reset between the branch and its follower must clear the pending marker.
    instr.indirect_branch = 1'b1;
    op(FGSS_OP_NONE, 0, 0, 0);
    nrst = 0;
    @(posedge clk);
    #1 nrst = 1;
    op(FGSS_OP_NONE, 0, 0, 0);
    chk(g_cpf, 0);
    stop_test();
  end
endmodule
bind fgss_guard fgss_guard_props u_props (.clk, .nrst, .instr, .master_guard_enable,
  .protected_mode_enable, .virtual8086_flag, .mrsp, .mreq, .busy, .shadow_enabled_query,
  .control_protection_fault, .fault_vector, .page_fault, .store_blocked, .ssp);
